/* sscs_top.sv */
// Sequencer top: start capture, channel walk, result store and host bus.
// Assumes host pins and comparator are synchronous to clk; the analog
// track/holds, input mux and DAC sit outside and follow the outputs here.
`timescale 1ns/1ps
`include "sscs_defs.svh"

// Operation
// (R1) Convert start rising edge puts all track/holds into hold, starts sequence.
// (R2) Select source low uses channel pick pins, high uses channel select register.
// (R3) Host writes channel select register with chip select, write strobe, low data lines.
// (R4) Selection latched at convert start rising edge; changes apply to next sequence.
// (R5) Busy rises at convert start rising edge, stays high whole sequence.
// (R6) Conversion clock internal, or external clock input when clock source pick high.
// (R7) Each channel completion signalled on active-low end-of-conversion output.
// (R8) Sequence end drops busy and returns all track/holds to tracking.
// (R9) Host reads after busy falls or one result per end-of-conversion pulse.
// (R10) Results read over 14-bit bus with chip select and read strobe.
// (R11) Each selected channel converts within 2.4 us.
// (R12) Host waits 350 ns acquisition after sequence end before next start.
// (R13) Host avoids reads during conversion and 100 ns before next start.
// (R14) Register bit 0 marks channel one, bit 3 marks channel four.
// (R15) Selected channels convert in ascending order regardless of selection order.
// (R16) End-of-conversion is a low-going pulse, not a held level.
// (R17) Twos complement for bipolar variants, straight binary for unipolar.
// (R18) Successive reads return results in conversion order, one per read.
module sscs_top #(
   parameter int TICK_CYCLES = `SSCS_TICK_CYCLES,
   parameter int EOC_PULSE_CYCLES = `SSCS_EOC_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic convert_start_n,
   input wire sscs_pkg::sscs_mask_t channel_pick_pins,
   input wire logic select_source,
   input wire logic clock_source_pick,
   input wire logic external_clock_input,
   input wire logic bipolar_coding,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire sscs_pkg::sscs_word_t db_i,
   output sscs_pkg::sscs_word_t db_o,
   output logic db_oe,
   output logic busy,
   output logic eoc_n,
   output sscs_pkg::sscs_mask_t hold,
   output sscs_pkg::sscs_chan_t mux_channel,
   output sscs_pkg::sscs_word_t dac_code,
   input wire logic comp_in
);
   import sscs_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic sscs_chan_t first_set(input sscs_mask_t m);
      sscs_chan_t idx;
      idx = '0;
      for (int i = `SSCS_NCH - 1; i >= 0; i--)
      begin
         if (m[i])
         begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [2:0] pop_count(input sscs_mask_t m);
      logic [2:0] n;
      n = '0;
      for (int i = 0; i < `SSCS_NCH; i++)
      begin
         n = n + {2'h0, m[i]};
      end
      return n;
   endfunction

   // Engine yields offset binary; flipping the top bit gives twos complement
   function automatic sscs_word_t fmt_result(input sscs_word_t code, input logic bip);
      return {code[`SSCS_RES_W-1] ^ bip, code[`SSCS_RES_W-2:0]};
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sscs_seq_state_t seq_q;
   logic cvst_prev_q;
   logic start_edge;
   logic [`SSCS_CSR_W-1:0] csr_q;
   logic wr_act_prev_q;
   logic rd_act_prev_q;
   logic wr_act;
   logic rd_act;
   sscs_mask_t pending_q;
   logic [2:0] total_q;
   logic sar_start_q;
   logic sar_busy;
   logic [7:0] div_q;
   logic ext_prev_q;
   logic tick_q;
   sscs_word_t store_q [`SSCS_STORE_DEPTH];
   logic [1:0] wptr_q;
   logic [1:0] rptr_q;
   logic [2:0] stored_q;
   logic store_wr;
   logic [7:0] eoc_cnt_q;
   logic busy_q;
   logic eoc_n_q;
   sscs_mask_t hold_q;
   sscs_chan_t chan_q;
   sscs_word_t db_o_q;
   logic db_oe_q;

   sscs_stream_if sar_to_buf ();
   sscs_stream_if buf_to_store ();

   assign start_edge = convert_start_n & ~cvst_prev_q;
   assign wr_act = ~cs_n & ~wr_n;
   assign rd_act = ~cs_n & ~rd_n;

   // ----------------------------------------------------------------
   // Conversion clock
   // ----------------------------------------------------------------
   // Internal divider spaces ticks so sixteen of them fit one channel slot
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         div_q <= '0;
         ext_prev_q <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         ext_prev_q <= external_clock_input;
         if (div_q == 8'(TICK_CYCLES - 1))
         begin
            div_q <= '0;
         end
         else
         begin
            div_q <= div_q + 8'h01;
         end
         if (clock_source_pick) // R6
         begin
            tick_q <= external_clock_input & ~ext_prev_q;
         end
         else
         begin
            tick_q <= (div_q == 8'(TICK_CYCLES - 1)); // R11
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel select register
   // ----------------------------------------------------------------
   // Taken at the end of the write strobe, when the data lines are settled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         csr_q <= `SSCS_CSR_RESET;
         wr_act_prev_q <= 1'b0;
      end
      else
      begin
         wr_act_prev_q <= wr_act;
         if (wr_act_prev_q & ~wr_act)
         begin
            csr_q <= db_i[`SSCS_CSR_W-1:0]; // R3 R14
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequence control
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         seq_q <= SEQ_IDLE;
         cvst_prev_q <= 1'b1;
         pending_q <= '0;
         total_q <= '0;
         sar_start_q <= 1'b0;
         chan_q <= '0;
         busy_q <= 1'b0;
         hold_q <= '0;
      end
      else
      begin
         cvst_prev_q <= convert_start_n;
         sar_start_q <= 1'b0;
         unique case (seq_q)
            SEQ_IDLE:
            begin
               // A start edge during a sequence is ignored
               if (start_edge)
               begin
                  pending_q <= select_source ? csr_q : channel_pick_pins; // R2 R4
                  total_q <= pop_count(select_source ? csr_q : channel_pick_pins);
                  hold_q <= '1; // R1
                  busy_q <= 1'b1; // R5
                  seq_q <= SEQ_RUN;
               end
            end
            SEQ_RUN:
            begin
               if (pending_q != '0 && !sar_busy && !sar_start_q)
               begin
                  chan_q <= first_set(pending_q); // R15
                  pending_q[first_set(pending_q)] <= 1'b0;
                  sar_start_q <= 1'b1;
               end
               else if (pending_q == '0 && stored_q == total_q)
               begin
                  seq_q <= SEQ_DONE;
               end
            end
            SEQ_DONE:
            begin
               busy_q <= 1'b0; // R8
               hold_q <= '0; // R8
               seq_q <= SEQ_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Conversion engine and buffer
   // ----------------------------------------------------------------
   sscs_sar u_sar (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(sar_start_q),
      .tick(tick_q),
      .comp_in(comp_in),
      .dac_code(dac_code),
      .sar_busy(sar_busy),
      .res_s(sar_to_buf)
   );

   sscs_buf2 #(
      .DEPTH(2)
   ) u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_s(sar_to_buf),
      .out_s(buf_to_store)
   );

   assign buf_to_store.ready = (stored_q != 3'(`SSCS_STORE_DEPTH));
   assign store_wr = buf_to_store.valid & buf_to_store.ready;

   // ----------------------------------------------------------------
   // Result store
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (store_wr)
      begin
         store_q[wptr_q] <= fmt_result(buf_to_store.data, bipolar_coding); // R17
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
         stored_q <= '0;
         rd_act_prev_q <= 1'b0;
      end
      else
      begin
         rd_act_prev_q <= rd_act;
         if (seq_q == SEQ_IDLE && start_edge)
         begin
            wptr_q <= '0;
            rptr_q <= '0;
            stored_q <= '0;
         end
         else
         begin
            if (store_wr)
            begin
               wptr_q <= wptr_q + 2'h1;
               stored_q <= stored_q + 3'h1;
            end
            // One result consumed per finished read cycle
            if (rd_act_prev_q & ~rd_act)
            begin
               rptr_q <= rptr_q + 2'h1; // R18
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // End-of-conversion pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         eoc_cnt_q <= '0;
         eoc_n_q <= 1'b1;
      end
      else if (store_wr)
      begin
         eoc_cnt_q <= 8'(EOC_PULSE_CYCLES - 1);
         eoc_n_q <= 1'b0; // R7
      end
      else if (eoc_cnt_q != '0)
      begin
         eoc_cnt_q <= eoc_cnt_q - 8'h01;
         eoc_n_q <= 1'b0;
      end
      else
      begin
         eoc_n_q <= 1'b1; // R16
      end
   end

   // ----------------------------------------------------------------
   // Host read port
   // ----------------------------------------------------------------
   // Data lags the strobe by one cycle; the host strobe spans many cycles
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         db_o_q <= '0;
         db_oe_q <= 1'b0;
      end
      else
      begin
         db_oe_q <= rd_act; // R10
         db_o_q <= store_q[rptr_q];
      end
   end

   assign db_o = db_o_q;
   assign db_oe = db_oe_q;
   assign busy = busy_q;
   assign eoc_n = eoc_n_q;
   assign hold = hold_q;
   assign mux_channel = chan_q;
endmodule

/* sscs_defs.svh */
// Constants of the simultaneous sample conversion sequencer.
// Assumes a 100 MHz system clock; included by package and modules.
`ifndef SSCS_DEFS_SVH
`define SSCS_DEFS_SVH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define SSCS_RES_W 14
`define SSCS_NCH 4
`define SSCS_CSR_W 4
`define SSCS_CSR_RESET 4'hF
`define SSCS_STORE_DEPTH 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSCS_CLK_PERIOD_NS 10
`define SSCS_CONV_TIME_NS 2400
`define SSCS_CONV_CYCLES (`SSCS_CONV_TIME_NS / `SSCS_CLK_PERIOD_NS)
`define SSCS_SAR_STEPS 16
`define SSCS_TICK_CYCLES (`SSCS_CONV_CYCLES / `SSCS_SAR_STEPS)
`define SSCS_ACQ_TIME_NS 350
`define SSCS_QUIET_TIME_NS 100
`define SSCS_EOC_PULSE_CYCLES 4

`endif

/* sscs_pkg.sv */
// Types shared by the sequencer modules.
// Assumes sscs_defs.svh is on the include path.
`include "sscs_defs.svh"

package sscs_pkg;
   typedef logic [`SSCS_RES_W-1:0] sscs_word_t;
   typedef logic [`SSCS_NCH-1:0] sscs_mask_t;
   typedef logic [1:0] sscs_chan_t;
   typedef enum logic [1:0] {SAR_IDLE, SAR_STEP, SAR_OUT} sscs_sar_state_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} sscs_seq_state_t;
endpackage

/* sscs_stream_if.sv */
// Valid/ready word stream between the sequencer's own modules.
// Assumes both ends share the system clock.
`timescale 1ns/1ps

interface sscs_stream_if;
   logic valid;
   logic ready;
   sscs_pkg::sscs_word_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* sscs_buf2.sv */
// Two-entry buffer in the result path.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps

module sscs_buf2 #(
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   sscs_stream_if.snk in_s,
   sscs_stream_if.src out_s
);
   import sscs_pkg::*;

   sscs_word_t mem_q [DEPTH];
   logic [$clog2(DEPTH)-1:0] wp_q;
   logic [$clog2(DEPTH)-1:0] rp_q;
   logic [$clog2(DEPTH):0] cnt_q;
   logic push;
   logic pop;

   assign in_s.ready = (cnt_q != ($clog2(DEPTH) + 1)'(DEPTH));
   assign out_s.valid = (cnt_q != '0);
   assign out_s.data = mem_q[rp_q];
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wp_q] <= in_s.data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop)
         begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
      end
   end
endmodule

/* sscs_sar.sv */
// Successive approximation engine: one bit decided per conversion tick.
// Assumes an external comparator, high when input is at or above dac_code.
`timescale 1ns/1ps
`include "sscs_defs.svh"

module sscs_sar (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic tick,
   input wire logic comp_in,
   output sscs_pkg::sscs_word_t dac_code,
   output logic sar_busy,
   sscs_stream_if.src res_s
);
   import sscs_pkg::*;

   sscs_sar_state_t state_q;
   sscs_word_t code_q;
   sscs_word_t trial_q;

   assign dac_code = code_q;
   assign sar_busy = (state_q != SAR_IDLE);
   assign res_s.valid = (state_q == SAR_OUT);
   assign res_s.data = code_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= SAR_IDLE;
         code_q <= '0;
         trial_q <= '0;
      end
      else
      begin
         unique case (state_q)
            SAR_IDLE:
            begin
               if (start)
               begin
                  code_q <= {1'b1, {(`SSCS_RES_W-1){1'b0}}};
                  trial_q <= {1'b1, {(`SSCS_RES_W-1){1'b0}}};
                  state_q <= SAR_STEP;
               end
            end
            SAR_STEP:
            begin
               if (tick)
               begin
                  // Keep the trial bit only if the input reached it
                  code_q <= (comp_in ? code_q : (code_q & ~trial_q)) | (trial_q >> 1);
                  trial_q <= trial_q >> 1;
                  if (trial_q[0])
                  begin
                     state_q <= SAR_OUT;
                  end
               end
            end
            SAR_OUT:
            begin
               // Stalls here while the buffer is full, so no word is lost
               if (res_s.ready)
               begin
                  state_q <= SAR_IDLE;
               end
            end
         endcase
      end
   end
endmodule

/* sscs_checker_assertions.sv */
// Concurrent checks on the sequencer top ports.
// Assumes it is bound into sscs_top; one clock, synchronous reset.
`timescale 1ns/1ps
module sscs_checker #(
   parameter int TICK_CYCLES = 15,
   parameter int EOC_PULSE_CYCLES = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic convert_start_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic db_oe,
   input wire logic busy,
   input wire logic eoc_n,
   input wire sscs_pkg::sscs_mask_t hold,
   input wire sscs_pkg::sscs_chan_t mux_channel
);
   import sscs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pulse width matches the default EOC_PULSE_CYCLES only
   sequence eoc_low_run;
      !eoc_n [*4] ##1 eoc_n;
   endsequence
   sequence start_seen;
      $rose(convert_start_n) && !busy && !$past(busy) && !$past(busy, 2);
   endsequence
   AST_START_BUSY: assert property (start_seen |=> busy)
      else $error("busy not raised after start edge");
   AST_HOLD_BUSY: assert property (hold == (busy ? 4'hF : 4'h0))
      else $error("hold bits disagree with busy");
   AST_EOC_PULSE: assert property ($fell(eoc_n) |-> eoc_low_run)
      else $error("end of conversion pulse has wrong width");
   AST_EOC_BUSY: assert property ($fell(eoc_n) |-> busy)
      else $error("end of conversion outside a sequence");
   AST_OE_ON: assert property (!cs_n && !rd_n |=> db_oe)
      else $error("data lines not driven during read");
   AST_OE_OFF: assert property ((cs_n || rd_n) |=> !db_oe)
      else $error("data lines driven outside read");
   AST_MUX_UP: assert property (busy && $past(busy) && $past(busy, 2) && mux_channel != $past(mux_channel)
      |-> mux_channel > $past(mux_channel))
      else $error("channel order not ascending");
   AST_SEQ_BOUND: assert property ($rose(busy) |-> ##[1:1000] !busy)
      else $error("sequence too long");
endmodule

/* sscs_afe_model.sv */
// Track/holds and comparator standing in for the analog side.
// Assumes hold high means hold; input levels come from the bench.
`timescale 1ns/1ps
module sscs_afe_model (
   input wire logic clk,
   input wire sscs_pkg::sscs_mask_t hold,
   input wire sscs_pkg::sscs_chan_t mux_channel,
   input wire sscs_pkg::sscs_word_t dac_code,
   input wire sscs_pkg::sscs_word_t level [4],
   output logic comp_in
);
   import sscs_pkg::*;
   sscs_word_t held_q [4];
   // Each channel freezes on its own hold bit
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
         if (!hold[i])
            held_q[i] <= level[i];
   end
   assign comp_in = held_q[mux_channel] >= dac_code;
endmodule

/* sscs_tb_top.sv */
// Self-checking bench for the sequencer top.
// Assumes the checker and analog model files are compiled first.
`timescale 1ns/1ps
module sscs_tb_top;
   import sscs_pkg::*;
   localparam int TICK = 2;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic convert_start_n = 1'b1;
   sscs_mask_t channel_pick_pins = 4'h0;
   logic select_source = 1'b0;
   logic clock_source_pick = 1'b0;
   logic external_clock_input = 1'b0;
   logic bipolar_coding = 1'b0;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   sscs_word_t db_i = 14'h0000;
   sscs_word_t db_o, dac_code;
   logic db_oe, busy, eoc_n, comp_in;
   sscs_mask_t hold;
   sscs_chan_t mux_channel;
   sscs_word_t level [4];
   sscs_word_t snap [4];
   int n_fail = 0;
   int num_checks = 0;
   int ext_cnt = 0;

   always #5 clk = ~clk;
   // External clock stands low unless picked
   always @(negedge clk)
   begin
      ext_cnt <= (ext_cnt + 1) % 6;
      external_clock_input <= clock_source_pick && ext_cnt < 3;
   end

   sscs_top #(.TICK_CYCLES(TICK), .EOC_PULSE_CYCLES(4)) sscs_top_i (.clk(clk), .sys_rst(sys_rst),
      .convert_start_n(convert_start_n), .channel_pick_pins(channel_pick_pins), .select_source(select_source),
      .clock_source_pick(clock_source_pick), .external_clock_input(external_clock_input),
      .bipolar_coding(bipolar_coding), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .db_i(db_i), .db_o(db_o),
      .db_oe(db_oe), .busy(busy), .eoc_n(eoc_n), .hold(hold), .mux_channel(mux_channel),
      .dac_code(dac_code), .comp_in(comp_in));
   sscs_afe_model sscs_afe_model_i (.clk(clk), .hold(hold), .mux_channel(mux_channel),
      .dac_code(dac_code), .level(level), .comp_in(comp_in));

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input sscs_word_t seen, input sscs_word_t exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bounded wait on busy (sel 0) or eoc_n (sel 1)
   task automatic wait_sig(input int sel, input logic val, input int lim);
      for (int i = 0; i < lim; i++)
      begin
         @(negedge clk);
         if ((sel == 1 ? eoc_n : busy) === val)
            return;
      end
      n_fail++;
      give_verdict();
   endtask

   task automatic wr_sel(input sscs_mask_t m);
      @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      db_i = {10'h000, m};
      @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
   endtask

   // Start pulse alone; the rising edge is sampled at the next clock
   task automatic pulse_start();
      @(negedge clk);
      convert_start_n = 1'b0;
      @(negedge clk);
      convert_start_n = 1'b1;
   endtask

   // Start, then move the inputs once hold is on
   task automatic start_seq();
      pulse_start();
      wait_sig(0, 1'b1, 10);
      snap = level;
      for (int i = 0; i < 4; i++)
         level[i] = level[i] + 14'h0111;
   endtask

   task automatic rd_chk(input sscs_word_t exp);
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(sscs_word_t'(db_oe), 14'h0001);
      chk(db_o, exp);
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask

   function automatic sscs_word_t ex(input int c);
      return snap[c] ^ (bipolar_coding ? 14'h2000 : 14'h0000);
   endfunction

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      level = '{14'h0123, 14'h1ABC, 14'h2F00, 14'h3FFF};
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      chk(sscs_word_t'({mux_channel, busy, eoc_n, db_oe, hold}), 14'h0020);
      chk(db_o, 14'h0000);
      channel_pick_pins = 4'b1101;
      start_seq();
      // Second start while busy must be ignored; held values stay
      pulse_start();
      chk(sscs_word_t'(busy), 14'h0001);
      wait_sig(0, 1'b0, 3000);
      rd_chk(ex(0));
      rd_chk(ex(2));
      rd_chk(ex(3));
      $display("test pin selection done");
      repeat (40) @(negedge clk);
      select_source = 1'b1;
      channel_pick_pins = 4'b0001;
      bipolar_coding = 1'b1;
      wr_sel(4'b0110);
      start_seq();
      wr_sel(4'b1000);
      wait_sig(0, 1'b0, 3000);
      rd_chk(ex(1));
      rd_chk(ex(2));
      repeat (40) @(negedge clk);
      start_seq();
      wait_sig(0, 1'b0, 3000);
      rd_chk(ex(3));
      $display("test register selection done");
      repeat (40) @(negedge clk);
      select_source = 1'b0;
      channel_pick_pins = 4'b1111;
      bipolar_coding = 1'b0;
      clock_source_pick = 1'b1;
      start_seq();
      for (int c = 0; c < 4; c++)
      begin
         wait_sig(1, 1'b0, 1000);
         rd_chk(ex(c));
         wait_sig(1, 1'b1, 10);
      end
      wait_sig(0, 1'b0, 100);
      chk(sscs_word_t'(hold), 14'h0000);
      $display("test external clock done");
      repeat (40) @(negedge clk);
      channel_pick_pins = 4'h0;
      start_seq();
      wait_sig(0, 1'b0, 10);
      chk(sscs_word_t'(eoc_n), 14'h0001);
      $display("test empty selection done");
      give_verdict();
   end
endmodule

bind sscs_top sscs_checker #(.TICK_CYCLES(TICK_CYCLES), .EOC_PULSE_CYCLES(EOC_PULSE_CYCLES)) sscs_checker_i (
   .clk(clk), .sys_rst(sys_rst), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
   .db_oe(db_oe), .busy(busy), .eoc_n(eoc_n), .hold(hold), .mux_channel(mux_channel));
